/* File: rtl/ads_pkg.sv */
// package for the antenna diversity select block
`default_nettype none
package ads_pkg;
   localparam int ADS_CLK_PERIOD_NS = 10;
   // select goes high this long after receive enable rises
   localparam int ADS_SEL_DELAY_NS = 135;
   localparam int ADS_SEL_DELAY_CYC = (ADS_SEL_DELAY_NS + ADS_CLK_PERIOD_NS - 1) / ADS_CLK_PERIOD_NS;
   // pin rise to wait entry takes five edges, leaving wait one more
   localparam int ADS_RISE_LAT_CYC = 6;
   // long preamble the far end must send in dual mode
   localparam int ADS_LONG_PREAMBLE_SYM = 126;
   localparam int ADS_DWELL_CYC = 64;
   localparam int ADS_SCORE_W = 8;
   localparam int ADS_HDR_MODE_W = 2;
   localparam int ADS_SINGLE_ANT_POS = 6;
   localparam logic ADS_ANT_RESET = 1'b0;
   localparam logic ADS_ANT_B = 1'b1;
   typedef enum logic [1:0] {
      ADS_IDLE = 2'b00,
      ADS_WAIT = 2'b01,
      ADS_ACQ = 2'b11,
      ADS_HOLD = 2'b10
   } ads_state_e;
   // header format field enables: sfd, crc16, length, full header
   function automatic logic [3:0] ads_hdr_fields(input logic [ADS_HDR_MODE_W-1:0] mode);
      case (mode)
         2'h0: ads_hdr_fields = 4'h1;
         2'h1: ads_hdr_fields = 4'h3;
         2'h2: ads_hdr_fields = 4'h7;
         default: ads_hdr_fields = 4'hF;
      endcase
   endfunction : ads_hdr_fields
endpackage : ads_pkg
`default_nettype wire

/* File: rtl/ads_sync3.sv */
// three-stage pin synchroniser with agreement check
`default_nettype none
module ads_sync3 (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic d_in,
   output logic q_out
);
   logic [2:0] s_r;
   logic [2:0] s_nxt;
   logic q_r;
   logic q_nxt;
   always_comb begin
      s_nxt = ce_in ? {s_r[1:0], d_in} : s_r;
      // only bits 1 and 2 are compared, stage 0 is metastable
      q_nxt = (ce_in && (s_r[1] == s_r[2])) ? s_r[2] : q_r;
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_r <= 3'h0;
         q_r <= 1'b0;
      end else begin
         s_r <= s_nxt;
         q_r <= q_nxt;
      end
   end
   assign q_out = q_r;
endmodule : ads_sync3
`default_nettype wire

/* File: rtl/ads_top.sv */
// antenna diversity selection for the baseband receiver
// Overview of operation
// [RULE1] In dual mode the far transmitter sends a 126-symbol long preamble so both antennas get a dwell.
// [RULE2] During dual-mode acquisition the antenna choice toggles every dwell.
// [RULE3] After verification the choice holds until half duplex transmit enable is asserted.
// [RULE4] A rising receive enable starts acquisition; while it is low the last choice is kept.
// [RULE5] If receive enable drops before verification in dual mode, the best stored score wins.
// [RULE6] The reset input clears the stored per-antenna scores.
// [RULE7] Low receive enable resets the toggle flop and the choice goes high 135 ns after the rise; the code keeps the choice while it is low.
// [RULE8] Mode bit 0 is dual antenna, 1 is single antenna, which also needs bit 6 of control register five.
// [RULE9] Header mode bits pick a header format with its own field combination.
// [RULE10] In single mode the antenna choice stays static during acquisition.
`default_nettype none
module ads_top
   import ads_pkg::*;
#(
   parameter int DWELL_CYC = ADS_DWELL_CYC,
   parameter int SCORE_W = ADS_SCORE_W
) (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   // pins
   input wire logic receive_enable_in,
   input wire logic transmit_enable_in,
   input wire logic score_reset_in,
   // correlator
   input wire logic [SCORE_W-1:0] signal_quality_score_in,
   input wire logic verify_in,
   // configuration
   input wire logic single_ant_mode_in,
   input wire logic [7:0] control_reg_five_in,
   input wire logic half_duplex_in,
   input wire logic [ADS_HDR_MODE_W-1:0] hdr_mode_in,
   // status
   output logic antenna_choice_out,
   output logic acquiring_out,
   output logic cfg_mismatch_out,
   output logic [3:0] hdr_fields_out
);
   logic rst_s1_r;
   logic rst_n_r;
   logic rx_en;
   logic tx_en;
   logic sc_rst;
   ads_state_e state_r;
   ads_state_e state_nxt;
   logic ant_r;
   logic ant_nxt;
   logic rx_d_r;
   logic rx_d_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [SCORE_W-1:0] sc_a_r;
   logic [SCORE_W-1:0] sc_a_nxt;
   logic [SCORE_W-1:0] sc_b_r;
   logic [SCORE_W-1:0] sc_b_nxt;
   logic [SCORE_W-1:0] peak_r;
   logic [SCORE_W-1:0] peak_nxt;
   logic mis_r;
   logic mis_nxt;
   logic [3:0] hdr_r;
   logic [3:0] hdr_nxt;
   logic tx_hold;

   // reset enters asynchronously but leaves on the clock
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   ads_sync3 u_rx (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .ce_in(ce_in),
      .d_in(receive_enable_in),
      .q_out(rx_en)
   );
   ads_sync3 u_tx (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .ce_in(ce_in),
      .d_in(transmit_enable_in),
      .q_out(tx_en)
   );
   ads_sync3 u_sr (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .ce_in(ce_in),
      .d_in(score_reset_in),
      .q_out(sc_rst)
   );

   // full duplex transmit never releases a held choice
   assign tx_hold = half_duplex_in && tx_en;

   always_comb begin
      state_nxt = state_r;
      ant_nxt = ant_r;
      rx_d_nxt = rx_en;
      cnt_nxt = cnt_r;
      sc_a_nxt = sc_a_r;
      sc_b_nxt = sc_b_r;
      peak_nxt = peak_r;
      case (state_r)
         ADS_IDLE: begin
            // [RULE4] rising receive enable starts acquisition
            if (rx_en && !rx_d_r) begin
               state_nxt = ADS_WAIT;
               cnt_nxt = 16'h0000;
               peak_nxt = '0;
            end
         end
         ADS_WAIT: begin
            // [RULE7] antenna b after the fixed delay
            // sync, agreement and edge detect already spent part of it
            if (!rx_en) begin
               state_nxt = ADS_IDLE;
            end else if (cnt_r >= 16'(ADS_SEL_DELAY_CYC - ADS_RISE_LAT_CYC)) begin
               state_nxt = ADS_ACQ;
               ant_nxt = ADS_ANT_B;
               cnt_nxt = 16'h0000;
            end else begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
         ADS_ACQ: begin
            if (signal_quality_score_in > peak_r) begin
               peak_nxt = signal_quality_score_in;
            end
            if (!rx_en) begin
               state_nxt = ADS_IDLE;
               // [RULE5] best stored score decides
               if (!single_ant_mode_in) begin
                  // a tie goes to b, the first dwell's antenna
                  ant_nxt = (sc_a_r > sc_b_r) ? 1'b0 : 1'b1;
               end
            end else if (verify_in) begin
               // [RULE3] choice now frozen
               state_nxt = ADS_HOLD;
            end else if (cnt_r == 16'(DWELL_CYC - 1)) begin
               cnt_nxt = 16'h0000;
               peak_nxt = '0;
               if (ant_r) begin
                  sc_b_nxt = peak_r;
               end else begin
                  sc_a_nxt = peak_r;
               end
               // [RULE2] toggle per dwell, [RULE10] not in single mode
               if (!single_ant_mode_in) begin
                  ant_nxt = !ant_r;
               end
            end else begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
         ADS_HOLD: begin
            // [RULE3] release on half duplex transmit
            if (tx_hold || !rx_en) begin
               state_nxt = ADS_IDLE;
            end
         end
         default: begin
            state_nxt = ADS_IDLE;
         end
      endcase
      // [RULE6] reset pin clears scores
      if (sc_rst) begin
         sc_a_nxt = '0;
         sc_b_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ADS_IDLE;
         ant_r <= ADS_ANT_RESET;
         rx_d_r <= 1'b0;
         cnt_r <= 16'h0000;
         sc_a_r <= '0;
         sc_b_r <= '0;
         peak_r <= '0;
      end else if (ce_in) begin
         state_r <= state_nxt;
         ant_r <= ant_nxt;
         rx_d_r <= rx_d_nxt;
         cnt_r <= cnt_nxt;
         sc_a_r <= sc_a_nxt;
         sc_b_r <= sc_b_nxt;
         peak_r <= peak_nxt;
      end
   end

   // config status: registered straight from the ports
   always_comb begin
      // [RULE8] single mode needs bit 6 too
      mis_nxt = single_ant_mode_in && !control_reg_five_in[ADS_SINGLE_ANT_POS];
      // [RULE9] header format decode
      hdr_nxt = ads_hdr_fields(hdr_mode_in);
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mis_r <= 1'b0;
         hdr_r <= 4'h0;
      end else if (ce_in) begin
         mis_r <= mis_nxt;
         hdr_r <= hdr_nxt;
      end
   end

   assign antenna_choice_out = ant_r;
   assign acquiring_out = (state_r == ADS_ACQ);
   assign cfg_mismatch_out = mis_r;
   assign hdr_fields_out = hdr_r;
endmodule : ads_top
`default_nettype wire

/* File: testbench/ads_top_asserts.sv */
// port checks for the antenna diversity select block
`default_nettype none
module ads_top_asserts #(
   parameter int DWELL_CYC = 64
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // inputs
   input wire logic receive_enable_in,
   input wire logic transmit_enable_in,
   input wire logic verify_in,
   input wire logic single_ant_mode_in,
   input wire logic [7:0] control_reg_five_in,
   input wire logic [1:0] hdr_mode_in,
   // outputs
   input wire logic antenna_choice_out,
   input wire logic acquiring_out,
   input wire logic cfg_mismatch_out,
   input wire logic [3:0] hdr_fields_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TGL_MAX = DWELL_CYC + 1;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   property p_tgl; acquiring_out && !single_ant_mode_in |-> ##[1:TGL_MAX] ($changed(antenna_choice_out) || !acquiring_out); endproperty
   a_tgl: assert property (p_tgl) else $error("no toggle");
   property p_single; acquiring_out && $past(acquiring_out) && single_ant_mode_in |-> $stable(antenna_choice_out); endproperty
   a_single: assert property (p_single) else $error("single moved");
   property p_first_b; $rose(acquiring_out) |-> antenna_choice_out; endproperty
   a_first_b: assert property (p_first_b) else $error("first dwell not B");
   // tx excluded: half duplex transmit only releases the hold, it does not move it
   property p_keep; !acquiring_out && $past(!acquiring_out) && !transmit_enable_in |-> $stable(antenna_choice_out); endproperty
   a_keep: assert property (p_keep) else $error("choice moved");
   property p_rx_low; !receive_enable_in [*6] |-> !acquiring_out; endproperty
   a_rx_low: assert property (p_rx_low) else $error("acquiring while rx low");
   property p_verify; verify_in && acquiring_out |=> !acquiring_out; endproperty
   a_verify: assert property (p_verify) else $error("verify ignored");
   property p_mism; $stable({single_ant_mode_in, control_reg_five_in[6]}) [*5] |-> cfg_mismatch_out == (single_ant_mode_in && !control_reg_five_in[6]); endproperty
   a_mism: assert property (p_mism) else $error("mismatch flag");
   property p_hdr; $stable(hdr_mode_in) [*5] |-> hdr_fields_out == (4'hF >> (2'h3 - hdr_mode_in)); endproperty
   a_hdr: assert property (p_hdr) else $error("header fields");
   c_rise: cover property ($rose(acquiring_out));
   c_verify: cover property (verify_in && acquiring_out);
   c_single: cover property (acquiring_out && single_ant_mode_in);
endmodule : ads_top_asserts
bind ads_top ads_top_asserts #(.DWELL_CYC(DWELL_CYC)) u_ads_top_asserts (.clk_sys_in, .arst_n_in, .receive_enable_in,
   .transmit_enable_in, .verify_in, .single_ant_mode_in, .control_reg_five_in, .hdr_mode_in, .antenna_choice_out,
   .acquiring_out, .cfg_mismatch_out, .hdr_fields_out);
`default_nettype wire

/* File: testbench/ads_ant_switch.sv */
// antenna switch model: routes the selected antenna's score
`default_nettype none
module ads_ant_switch (
   // select and per-antenna quality
   input wire logic sel_in,
   input wire logic [7:0] score_a_in,
   input wire logic [7:0] score_b_in,
   output logic [7:0] score_out
);
   timeunit 1ns;
   timeprecision 1ps;
   assign score_out = sel_in ? score_b_in : score_a_in;
endmodule : ads_ant_switch
`default_nettype wire

/* File: testbench/ads_top_bench.sv */
// self-checking bench for the antenna diversity select block
`default_nettype none
module ads_top_bench
   import ads_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, arst_n_in = 1'b0, rx_en = 1'b0, tx_en = 1'b0, srst = 1'b0, verify = 1'b0;
   logic single = 1'b0, hdx = 1'b0, c;
   logic [7:0] score, sc_a = 8'h00, sc_b = 8'h00, crf = 8'h00;
   logic [1:0] hdr = 2'h0;
   logic choice, acq, mism;
   logic [3:0] flds;
   int fails = 0, tests_run = 0;
   initial forever #5 clk_sys_in = ~clk_sys_in;
   ads_top #(.DWELL_CYC(8)) u_ads_top (.clk_sys_in, .arst_n_in, .ce_in(1'b1), .receive_enable_in(rx_en),
      .transmit_enable_in(tx_en), .score_reset_in(srst), .signal_quality_score_in(score), .verify_in(verify),
      .single_ant_mode_in(single), .control_reg_five_in(crf), .half_duplex_in(hdx), .hdr_mode_in(hdr),
      .antenna_choice_out(choice), .acquiring_out(acq), .cfg_mismatch_out(mism), .hdr_fields_out(flds));
   ads_ant_switch u_ads_ant_switch (.sel_in(choice), .score_a_in(sc_a), .score_b_in(sc_b), .score_out(score));
   task cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : cyc
   task conclude;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   task chk(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %b want %b", $time, got, exp);
      end
   endtask : chk_bit
   task chk_cyc(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         fails++;
         $display("[FAIL] %0t took %0d cycles want %0d", $time, got, exp);
      end
   endtask : chk_cyc
   // counts edges from the receive enable rise to acquisition
   task wait_acq;
      int i;
      for (i = 0; i < 40 && acq !== 1'b1; i++)
         cyc(1);
      if (i == 40) begin
         fails++;
         $display("[FAIL] %0t acquisition never started", $time);
         conclude();
      end
      chk_cyc(i, ADS_SEL_DELAY_CYC);
   endtask : wait_acq
   // dual acquisition held n cycles, then dropped before verify
   task run(input logic [7:0] a, input logic [7:0] b, input int n, input logic exp);
      sc_a = a;
      sc_b = b;
      rx_en = 1'b1;
      wait_acq();
      chk_bit(choice, ADS_ANT_B);
      cyc(n);
      rx_en = 1'b0;
      cyc(10);
      chk_bit(choice, exp);
      cyc(10);
      chk_bit(choice, exp);
   endtask : run
   initial begin
      cyc(2);
      arst_n_in = 1'b1;
      cyc(6);
      run(8'h0A, 8'h5A, 40, 1'b1);
      run(8'h32, 8'h14, 40, 1'b0);
      srst = 1'b1;
      cyc(8);
      srst = 1'b0;
      cyc(6);
      // no dwell completes, so cleared scores tie
      run(8'h32, 8'h14, 1, 1'b1);
      rx_en = 1'b1;
      wait_acq();
      cyc(20);
      c = choice;
      verify = 1'b1;
      cyc(1);
      verify = 1'b0;
      // free toggling would also show antenna b at this point
      cyc(12);
      chk_bit(choice, c);
      cyc(18);
      chk_bit(choice, c);
      hdx = 1'b1;
      tx_en = 1'b1;
      cyc(10);
      {rx_en, tx_en, hdx} = 3'h0;
      cyc(12);
      single = 1'b1;
      crf = 8'h40;
      cyc(6);
      chk_bit(mism, 1'b0);
      rx_en = 1'b1;
      wait_acq();
      c = choice;
      cyc(30);
      chk_bit(choice, c);
      rx_en = 1'b0;
      crf = 8'h00;
      cyc(8);
      chk_bit(mism, 1'b1);
      single = 1'b0;
      for (int m = 0; m < 4; m++) begin
         hdr = m[1:0];
         cyc(6);
         chk(flds, 4'hF >> (2'h3 - hdr));
      end
      conclude();
   end
endmodule : ads_top_bench
`default_nettype wire
